// [design/dcpc_pkg.sv]
// Purpose: Shared constants and types for the DAC calibration/power-down controller
// Assumes: 100 MHz system clock, 3-wire serial port to the converter
// Notes:   Device offsets are 5-bit serial-port register addresses
package dcpc_pkg;
  // Device register addresses
  localparam logic [4:0] DEV_PD         = 5'h00;
  localparam logic [4:0] DEV_CFG        = 5'h02;
  localparam logic [4:0] DEV_DIV        = 5'h0E;
  localparam logic [4:0] DEV_CAL        = 5'h0F;
  localparam logic [4:0] DEV_CADDR      = 5'h10;
  localparam logic [4:0] DEV_CDATA      = 5'h11;
  // Calibration control values and bits
  localparam logic [7:0] CAL_START      = 8'h40;
  localparam logic [7:0] CAL_RDREQ      = 8'h04;
  localparam logic [7:0] CAL_WREN       = 8'h08;
  localparam logic [7:0] CAL_IDLE       = 8'h00;
  localparam int         CAL_DONE_BIT   = 7;
  localparam int         CFG_CALEN_BIT  = 0;
  localparam int         PD_CLKOFF_BIT  = 1;
  localparam int         PD_SLEEP_BIT   = 2;
  localparam int         PD_FULL_BIT    = 3;
  localparam int         DIV_W          = 3;
  // Coefficient store
  localparam int         NUM_COEF       = 33;
  localparam logic [5:0] LAST_COEF      = 6'h20;
  // Avalon byte offsets
  localparam logic [8:0] A_CMD          = 9'h000;
  localparam logic [8:0] A_CFG          = 9'h004;
  localparam logic [8:0] A_STAT         = 9'h008;
  localparam logic [8:0] A_WAIT         = 9'h00C;
  localparam logic [8:0] A_COEF         = 9'h100;
  // Command codes
  localparam logic [2:0] CMD_CAL        = 3'h1;
  localparam logic [2:0] CMD_RD         = 3'h2;
  localparam logic [2:0] CMD_WR         = 3'h3;
  localparam logic [2:0] CMD_PD         = 3'h4;
  // CFG field positions
  localparam int         CFG_PD_LSB     = 1;
  localparam int         CFG_DIV_LSB    = 4;
  localparam int         CFG_HI_LSB     = 9;
  // Timing
  localparam int         SYS_MHZ        = 100;
  localparam int         DAC_MIN_MHZ    = 10;
  localparam int         COEF_WAIT_SMP  = 160;
  localparam int         CAL_CYCLES     = 4500;
  localparam logic [15:0] WAIT_RESET    =
    16'((COEF_WAIT_SMP * SYS_MHZ + DAC_MIN_MHZ - 1) / DAC_MIN_MHZ);
  localparam logic [3:0] SPI_HALF       = 4'h4;
  localparam logic [4:0] SPI_BITS       = 5'h10;
  localparam logic [4:0] SPI_DATA_BIT   = 5'h08;

  typedef struct packed {
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } dcpc_spi_req_t;
endpackage

// [design/dcpc_spi.sv]
// Purpose: Serial port master for one 16-bit register access
// Assumes: Instruction byte {rd,2'b00,addr}, MSB first, device samples on rising sclk
// Notes:   SDIO is released during the data byte of a read
`timescale 1ns/1ns
module dcpc_spi
  import dcpc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          start,
  input  wire dcpc_spi_req_t req,
  output logic               busy,
  output logic               done,
  output logic [7:0]         rdata,
  output logic               sclk,
  output logic               csb,
  output logic               sdio_o,
  output logic               sdio_oe,
  input  wire logic          sdio_i
);
  logic [3:0]  tick_cnt,  next_tick_cnt;
  logic [4:0]  bit_cnt,   next_bit_cnt;
  logic [15:0] shift,     next_shift;
  logic        rd,        next_rd;
  logic        next_busy, next_done, next_sclk, next_csb, next_sdio_o, next_sdio_oe;
  logic [7:0]  next_rdata;
  logic        tick;

  always_comb begin
    tick          = (tick_cnt == SPI_HALF - 4'h1);
    next_tick_cnt = (busy && !tick) ? tick_cnt + 4'h1 : 4'h0;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_rd       = rd;
    next_busy     = busy;
    next_done     = 1'b0;
    next_sclk     = sclk;
    next_csb      = csb;
    next_sdio_o   = sdio_o;
    next_sdio_oe  = sdio_oe;
    next_rdata    = rdata;
    if (!busy && start) begin
      next_busy    = 1'b1;
      next_csb     = 1'b0;
      next_rd      = req.rd;
      next_shift   = {req.rd, 2'b00, req.addr, req.wdata};
      next_sdio_o  = req.rd;
      next_sdio_oe = 1'b1;
      next_bit_cnt = 5'h00;
    end else if (busy && tick) begin
      if (!sclk) begin
        next_sclk = 1'b1;
        if (rd && bit_cnt >= SPI_DATA_BIT) begin
          next_rdata = {rdata[6:0], sdio_i};
        end
      end else begin
        next_sclk    = 1'b0;
        next_bit_cnt = bit_cnt + 5'h01;
        next_shift   = {shift[14:0], 1'b0};
        next_sdio_o  = shift[14];
        next_sdio_oe = !(rd && (bit_cnt + 5'h01) >= SPI_DATA_BIT);
        if (bit_cnt == SPI_BITS - 5'h01) begin
          next_busy    = 1'b0;
          next_done    = 1'b1;
          next_csb     = 1'b1;
          next_sdio_oe = 1'b0;
          next_sdio_o  = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_cnt <= 4'h0;
      bit_cnt  <= 5'h00;
      shift    <= 16'h0000;
      rd       <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
      sclk     <= 1'b0;
      csb      <= 1'b1;
      sdio_o   <= 1'b0;
      sdio_oe  <= 1'b0;
      rdata    <= 8'h00;
    end else begin
      tick_cnt <= next_tick_cnt;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      rd       <= next_rd;
      busy     <= next_busy;
      done     <= next_done;
      sclk     <= next_sclk;
      csb      <= next_csb;
      sdio_o   <= next_sdio_o;
      sdio_oe  <= next_sdio_oe;
      rdata    <= next_rdata;
    end
  end
endmodule

// [design/dcpc_ctrl.sv]
// Purpose: Host controller running calibration, coefficient transfer and power-down
// Assumes: Avalon-MM slave with waitrequest, one access answered per request
// Notes:   Commands issued while busy are ignored
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
// What this block does
// - Host programs divider below 10 MHz
// - Calibration clock enabled around every calibration, read and write procedure (not power-down)
// - Writing 0x40 starts self-calibration
// - Write 0x00 before clock disable
// - Address at 0x10, data at 0x11
// - Read: address, 0x04 request, wait, read
// - Clear read request before next address
// - Write: 0x08 enable, then address, value
// - Step address by one over 33
// - Clear write enable, then clock off
module dcpc_ctrl
  import dcpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             dac_sclk,
  output logic             dac_csb,
  output logic             dac_sdio_o,
  output logic             dac_sdio_oe,
  input  wire logic        dac_sdio_i
);
  typedef enum logic [4:0] {
    S_IDLE, S_PD, S_CLKON, S_DIVW, S_CALGO, S_CALWAIT, S_CALPOLL,
    S_RADDR, S_RREQ, S_RWAIT, S_RDATA, S_RCLR,
    S_WEN, S_WADDR, S_WDATA, S_WWAIT, S_CTLCLR, S_CLKOFF
  } dcpc_state_t;

  dcpc_state_t   state, next_state;
  logic [2:0]    op, next_op;
  logic [2:0]    pd_bits, next_pd_bits;
  logic [2:0]    cal_clock_divider_select, next_cal_clock_divider_select;
  logic [6:0]    cfg_hi, next_cfg_hi;
  logic [15:0]   wait_cyc, next_wait_cyc;
  logic [15:0]   wait_cnt, next_wait_cnt;
  logic [5:0]    idx, next_idx;
  logic          pend, next_pend;
  logic          cal_done_flag, next_cal_done_flag;
  logic          op_done, next_op_done;
  logic          next_waitrequest;
  logic [31:0]   next_readdata;
  logic          spi_start, spi_busy, spi_done, access;
  logic [7:0]    spi_rdata;
  dcpc_spi_req_t spi_req;
  logic [7:0]    coef_mem [NUM_COEF];
  logic          mem_we;
  logic [5:0]    mem_addr;
  logic [7:0]    mem_wdata;
  logic          bus_rd, bus_wr;
  logic [5:0]    bus_idx;

  function automatic logic is_coef(input logic [8:0] a);
    return (a >= A_COEF) && (a < A_COEF + 9'(4 * NUM_COEF));
  endfunction

  function automatic logic [5:0] coef_idx(input logic [8:0] a);
    logic [8:0] d;
    d = a - A_COEF;
    return d[7:2];
  endfunction

  assign spi_start = access && !pend;

  dcpc_spi u_spi (
    .clk     (clk),
    .rstn    (rstn),
    .start   (spi_start),
    .req     (spi_req),
    .busy    (spi_busy),
    .done    (spi_done),
    .rdata   (spi_rdata),
    .sclk    (dac_sclk),
    .csb     (dac_csb),
    .sdio_o  (dac_sdio_o),
    .sdio_oe (dac_sdio_oe),
    .sdio_i  (dac_sdio_i)
  );

  // Bus decode and register file
  always_comb begin
    bus_rd                        = avs_read && avs_waitrequest;
    bus_wr                        = avs_write && !avs_waitrequest;
    bus_idx                       = coef_idx(avs_address);
    next_waitrequest              = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata                 = avs_readdata;
    next_pd_bits                  = pd_bits;
    next_cal_clock_divider_select = cal_clock_divider_select;
    next_cfg_hi                   = cfg_hi;
    next_wait_cyc                 = wait_cyc;
    if (bus_rd) begin
      next_readdata = 32'h0000_0000;
      if (avs_address == A_CFG) begin
        next_readdata = {16'h0000, cfg_hi, 1'b0, 1'b0, cal_clock_divider_select,
                         pd_bits, 1'b0};
      end else if (avs_address == A_STAT) begin
        next_readdata = {29'h0000_0000, op_done, cal_done_flag, state != S_IDLE};
      end else if (avs_address == A_WAIT) begin
        next_readdata = {16'h0000, wait_cyc};
      end else if (is_coef(avs_address)) begin
        next_readdata = {24'h00_0000, coef_mem[bus_idx]};
      end
    end
    if (bus_wr && state == S_IDLE) begin
      if (avs_address == A_CFG) begin
        next_pd_bits                  = avs_writedata[CFG_PD_LSB +: 3];
        next_cal_clock_divider_select = avs_writedata[CFG_DIV_LSB +: DIV_W];
        next_cfg_hi                   = avs_writedata[CFG_HI_LSB +: 7];
      end else if (avs_address == A_WAIT) begin
        next_wait_cyc = (avs_writedata[15:0] == 16'h0000) ? 16'h0001 : avs_writedata[15:0];
      end
    end
  end

  // Sequencer
  always_comb begin
    next_state         = state;
    next_op            = op;
    next_wait_cnt      = wait_cnt;
    next_idx           = idx;
    next_pend          = pend;
    next_cal_done_flag = cal_done_flag;
    next_op_done       = op_done;
    mem_we             = 1'b0;
    mem_addr           = idx;
    mem_wdata          = spi_rdata;
    access             = 1'b0;
    spi_req            = '{rd: 1'b0, addr: DEV_PD, wdata: 8'h00};
    if (spi_start) begin
      next_pend = 1'b1;
    end
    if (spi_done) begin
      next_pend = 1'b0;
    end
    unique case (state)
      S_IDLE: begin
        next_idx = 6'h00;
        if (bus_wr && avs_address == A_CMD) begin
          next_op      = avs_writedata[2:0];
          next_op_done = 1'b0;
          if (avs_writedata[2:0] == CMD_PD) begin
            next_state = S_PD;
          end else if (avs_writedata[2:0] == CMD_CAL ||
                       avs_writedata[2:0] == CMD_RD ||
                       avs_writedata[2:0] == CMD_WR) begin
            next_state = S_CLKON;
          end
          if (avs_writedata[2:0] == CMD_CAL) begin
            next_cal_done_flag = 1'b0;
          end
        end
      end
      S_PD: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_PD, wdata: {4'h0, pd_bits, 1'b0}};
        if (spi_done) begin
          next_state   = S_IDLE;
          next_op_done = 1'b1;
        end
      end
      S_CLKON: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CFG, wdata: {cfg_hi, 1'b1}};
        if (spi_done) begin
          next_state = (op == CMD_CAL) ? S_DIVW : (op == CMD_RD) ? S_RADDR : S_WEN;
        end
      end
      S_DIVW: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_DIV, wdata: {5'h00, cal_clock_divider_select}};
        if (spi_done) begin
          next_state = S_CALGO;
        end
      end
      S_CALGO: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CAL, wdata: CAL_START};
        if (spi_done) begin
          next_state    = S_CALWAIT;
          next_wait_cnt = wait_cyc;
        end
      end
      S_CALWAIT: begin
        next_wait_cnt = wait_cnt - 16'h0001;
        if (wait_cnt <= 16'h0001) begin
          next_state = S_CALPOLL;
        end
      end
      S_CALPOLL: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b1, addr: DEV_CAL, wdata: 8'h00};
        if (spi_done) begin
          if (spi_rdata[CAL_DONE_BIT]) begin
            next_cal_done_flag = 1'b1;
            next_state         = S_CTLCLR;
          end else begin
            next_state    = S_CALWAIT;
            next_wait_cnt = wait_cyc;
          end
        end
      end
      S_RADDR: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CADDR, wdata: {2'b00, idx}};
        if (spi_done) begin
          next_state = S_RREQ;
        end
      end
      S_RREQ: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CAL, wdata: CAL_RDREQ};
        if (spi_done) begin
          next_state    = S_RWAIT;
          next_wait_cnt = wait_cyc;
        end
      end
      S_RWAIT: begin
        next_wait_cnt = wait_cnt - 16'h0001;
        if (wait_cnt <= 16'h0001) begin
          next_state = S_RDATA;
        end
      end
      S_RDATA: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b1, addr: DEV_CDATA, wdata: 8'h00};
        if (spi_done) begin
          mem_we     = 1'b1;
          next_state = S_RCLR;
        end
      end
      S_RCLR: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CAL, wdata: CAL_IDLE};
        if (spi_done) begin
          next_idx   = idx + 6'h01;
          next_state = (idx == LAST_COEF) ? S_CLKOFF : S_RADDR;
        end
      end
      S_WEN: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CAL, wdata: CAL_WREN};
        if (spi_done) begin
          next_state = S_WADDR;
        end
      end
      S_WADDR: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CADDR, wdata: {2'b00, idx}};
        if (spi_done) begin
          next_state = S_WDATA;
        end
      end
      S_WDATA: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CDATA, wdata: coef_mem[idx]};
        if (spi_done) begin
          next_state    = S_WWAIT;
          next_wait_cnt = wait_cyc;
        end
      end
      S_WWAIT: begin
        next_wait_cnt = wait_cnt - 16'h0001;
        if (wait_cnt <= 16'h0001) begin
          next_idx   = idx + 6'h01;
          next_state = (idx == LAST_COEF) ? S_CTLCLR : S_WADDR;
        end
      end
      S_CTLCLR: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CAL, wdata: CAL_IDLE};
        if (spi_done) begin
          next_state = S_CLKOFF;
        end
      end
      S_CLKOFF: begin
        access  = 1'b1;
        spi_req = '{rd: 1'b0, addr: DEV_CFG, wdata: {cfg_hi, 1'b0}};
        if (spi_done) begin
          next_state   = S_IDLE;
          next_op_done = 1'b1;
        end
      end
    endcase
    if (bus_wr && state == S_IDLE && is_coef(avs_address)) begin
      mem_we    = 1'b1;
      mem_addr  = bus_idx;
      mem_wdata = avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      coef_mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state                    <= S_IDLE;
      op                       <= 3'h0;
      pd_bits                  <= 3'h0;
      cal_clock_divider_select <= 3'h0;
      cfg_hi                   <= 7'h00;
      wait_cyc                 <= WAIT_RESET;
      wait_cnt                 <= 16'h0000;
      idx                      <= 6'h00;
      pend                     <= 1'b0;
      cal_done_flag            <= 1'b0;
      op_done                  <= 1'b0;
      avs_waitrequest          <= 1'b1;
      avs_readdata             <= 32'h0000_0000;
    end else begin
      state                    <= next_state;
      op                       <= next_op;
      pd_bits                  <= next_pd_bits;
      cal_clock_divider_select <= next_cal_clock_divider_select;
      cfg_hi                   <= next_cfg_hi;
      wait_cyc                 <= next_wait_cyc;
      wait_cnt                 <= next_wait_cnt;
      idx                      <= next_idx;
      pend                     <= next_pend;
      cal_done_flag            <= next_cal_done_flag;
      op_done                  <= next_op_done;
      avs_waitrequest          <= next_waitrequest;
      avs_readdata             <= next_readdata;
    end
  end
endmodule

// [testbench/dcpc_ctrl_props.sv]
// Purpose: Port assertions for the calibration/power-down controller
// Assumes: 16-bit serial frames, 4 clk sclk half period
// Notes:   Bound to the controller from the testbench top
`timescale 1ns/1ns
module dcpc_ctrl_props
  import dcpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [8:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        dac_sclk,
  input wire logic        dac_csb,
  input wire logic        dac_sdio_o,
  input wire logic        dac_sdio_oe,
  input wire logic        dac_sdio_i
);
  logic [4:0] rise_cnt;
  logic [4:0] next_rise_cnt;
  logic       rd_frame;
  logic       next_rd_frame;
  logic       prev_sclk;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Sclk rises within the frame and the read flag of its first bit
  always_comb begin
    next_rise_cnt = rise_cnt;
    next_rd_frame = rd_frame;
    if (dac_csb) begin
      next_rise_cnt = 5'h00;
    end else if (dac_sclk && !prev_sclk) begin
      next_rise_cnt = rise_cnt + 5'h01;
      if (rise_cnt == 5'h00) next_rd_frame = dac_sdio_o;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rise_cnt  <= 5'h00;
      rd_frame  <= 1'b0;
      prev_sclk <= 1'b0;
    end else begin
      rise_cnt  <= next_rise_cnt;
      rd_frame  <= next_rd_frame;
      prev_sclk <= dac_sclk;
    end
  end

  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_sclk_high;
    dac_sclk [*4] ##1 !dac_sclk;
  endsequence

  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> s_ack;
  endproperty
  property p_half;
    $rose(dac_sclk) |-> s_sclk_high;
  endproperty
  property p_idle;
    dac_csb && $past(dac_csb) |-> !dac_sclk && !dac_sdio_oe;
  endproperty
  property p_count;
    $rose(dac_csb) |-> rise_cnt == 5'h10;
  endproperty
  property p_gap;
    $rose(dac_csb) |-> dac_csb [*2];
  endproperty
  property p_stable;
    dac_sclk && prev_sclk && dac_sdio_oe |-> $stable(dac_sdio_o);
  endproperty
  property p_release;
    rd_frame && rise_cnt > 5'h08 |-> !dac_sdio_oe;
  endproperty
  property p_drive;
    !dac_csb && rise_cnt < 5'h08 |-> dac_sdio_oe;
  endproperty

  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  a_half: assert property (p_half) else $error("sclk high time wrong");
  a_idle: assert property (p_idle) else $error("serial activity outside frame");
  a_count: assert property (p_count) else $error("frame sclk count wrong");
  a_gap: assert property (p_gap) else $error("frames too close");
  a_stable: assert property (p_stable) else $error("sdio moved while sclk high");
  a_release: assert property (p_release) else $error("sdio driven in read data");
  a_drive: assert property (p_drive) else $error("instruction not driven");
endmodule

// [testbench/dcpc_dev_model.sv]
// Purpose: Behavioural model of the converter register port
// Assumes: Bits sampled on sclk rise, read data driven after sclk fall
// Notes:   bad counts host sequencing faults
`timescale 1ns/1ns
module dcpc_dev_model
  import dcpc_pkg::*;
#(
  parameter int CAL_LEN = 10
)
(
  input  wire logic clk,
  input  wire logic sclk,
  input  wire logic csb,
  input  wire logic sdio,
  output logic      dev_o,
  output logic      dev_oe
);
  logic [7:0]  pd, cfg, div, cal, caddr, cdata, inst, rv;
  logic [7:0]  coef [0:NUM_COEF-1];
  logic [15:0] sh;
  int          cnt, timer, bad;

  initial begin
    {pd, cfg, div, cal, caddr, cdata, inst, rv, sh} = '0;
    cnt = 0;
    timer = 0;
    bad = 0;
    dev_o = 1'b0;
    dev_oe = 1'b0;
  end

  function automatic logic [7:0] rd_reg(input logic [4:0] a);
    case (a)
      DEV_PD:    return pd;
      DEV_CFG:   return cfg;
      DEV_DIV:   return div;
      DEV_CAL:   return cal;
      DEV_CADDR: return caddr;
      DEV_CDATA: return cdata;
      default:   return 8'h00;
    endcase
  endfunction

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    case (a)
      DEV_PD: pd = d;
      DEV_CFG: begin
        if (!d[0] && cal[6:0] != 7'h00) bad++;
        cfg = d;
      end
      DEV_DIV: div = d;
      DEV_CAL: begin
        if (!cfg[0] && d != CAL_IDLE) bad++;
        if (d == CAL_START) begin
          cal[7] = 1'b0;
          timer = CAL_LEN * (2 << div[2:0]);
        end
        if (d == CAL_RDREQ) cdata = coef[caddr];
        cal[6:0] = d[6:0];
      end
      DEV_CADDR: begin
        if (cal[2] || (d != 8'h00 && d != caddr + 8'h01)) bad++;
        caddr = d;
      end
      DEV_CDATA: begin
        cdata = d;
        if (cal[3]) coef[caddr] = d;
      end
      default: ;
    endcase
  endtask

  always @(posedge sclk) begin
    if (!csb) begin
      sh = {sh[14:0], sdio};
      cnt = cnt + 1;
      if (cnt == 8) inst = sh[7:0];
    end
  end

  always @(negedge sclk) begin
    if (!csb && inst[7] && cnt >= 8 && cnt < 16) begin
      if (cnt == 8) rv = rd_reg(inst[4:0]);
      dev_oe = 1'b1;
      dev_o = rv[15 - cnt];
    end
  end

  always @(posedge csb) begin
    if (cnt == 16 && !inst[7]) wr_reg(inst[4:0], sh[7:0]);
    cnt = 0;
    inst = 8'h00;
    dev_oe = 1'b0;
  end

  // Released line toggles; calibration runs only on a live clock
  always @(posedge clk) begin
    if (!dev_oe) dev_o = ~dev_o;
    if (timer > 0 && cfg[0] && !pd[1]) begin
      timer = timer - 1;
      if (timer == 0) cal[7] = 1'b1;
    end
  end
endmodule

// [testbench/dcpc_ctrl_tb.sv]
// Purpose: Self-checking bench for the calibration/power-down controller
// Assumes: Device model answers every serial frame
// Notes:   WAIT shortened to 4 cycles after the reset value check
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); end end
module dcpc_ctrl_tb;
  import dcpc_pkg::*;
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [8:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, cfgv;
  logic        dac_sclk, dac_csb, dac_sdio_o, dac_sdio_oe, dev_o, dev_oe, sdio;
  logic [2:0]  pdv [0:3] = '{3'h1, 3'h2, 3'h4, 3'h0};
  int          err_count = 0, checked = 0, cycles = 0;

  assign sdio = dac_sdio_oe ? dac_sdio_o : dev_o;

  dcpc_ctrl u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dac_sclk(dac_sclk), .dac_csb(dac_csb),
    .dac_sdio_o(dac_sdio_o), .dac_sdio_oe(dac_sdio_oe), .dac_sdio_i(sdio));
  dcpc_dev_model #(.CAL_LEN(10)) u_dev (.clk(clk), .sclk(dac_sclk), .csb(dac_csb),
    .sdio(sdio), .dev_o(dev_o), .dev_oe(dev_oe));

  function automatic logic [7:0] cval(input int i);
    return 8'(i * 7 + 17);
  endfunction

  task automatic av_acc(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 30000; i++) begin
      av_acc(1'b0, A_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    av_acc(1'b0, A_WAIT, 32'h0);
    `CHK(rd, 32'h0000_0640)
    av_acc(1'b0, 9'h010, 32'h0);
    `CHK(rd, 32'h0)
    av_acc(1'b1, A_WAIT, 32'h4);
    for (int k = 0; k < 4; k++) begin
      cfgv = 32'(pdv[k]) << CFG_PD_LSB | 32'h3 << CFG_DIV_LSB | 32'h5 << CFG_HI_LSB;
      av_acc(1'b1, A_CFG, cfgv);
      av_acc(1'b0, A_CFG, 32'h0);
      `CHK(rd, cfgv)
      av_acc(1'b1, A_CMD, 32'(CMD_PD));
      wait_idle();
      `CHK(u_dev.pd, {4'h0, pdv[k], 1'b0})
    end
    for (int c = 0; c < 2; c++) begin
      av_acc(1'b1, A_CMD, 32'(CMD_CAL));
      av_acc(1'b0, A_STAT, 32'h0);
      `CHK(rd[1:0], 2'b01)
      av_acc(1'b1, A_WAIT, 32'h9);
      wait_idle();
      `CHK(rd[2:1], 2'b11)
      `CHK({u_dev.cfg, u_dev.div[2:0], u_dev.cal[6:0]}, {8'h0A, 3'h3, 7'h00})
      av_acc(1'b0, A_WAIT, 32'h0);
      `CHK(rd, 32'h4)
    end
    for (int i = 0; i < NUM_COEF; i++) av_acc(1'b1, A_COEF + 9'(4 * i), 32'(cval(i)));
    av_acc(1'b1, A_CMD, 32'(CMD_WR));
    wait_idle();
    for (int i = 0; i < NUM_COEF; i++) `CHK(u_dev.coef[i], cval(i))
    for (int i = 0; i < NUM_COEF; i++) av_acc(1'b1, A_COEF + 9'(4 * i), 32'h0);
    av_acc(1'b1, A_CMD, 32'(CMD_RD));
    wait_idle();
    for (int i = 0; i < NUM_COEF; i++) begin
      av_acc(1'b0, A_COEF + 9'(4 * i), 32'h0);
      `CHK(rd, 32'(cval(i)))
    end
    `CHK(u_dev.bad, 0)
    `CHK({u_dev.cal[6:0], u_dev.cfg[0]}, 8'h00)
    print_verdict();
  end
endmodule

bind dcpc_ctrl dcpc_ctrl_props u_props (.clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dac_sclk(dac_sclk),
  .dac_csb(dac_csb), .dac_sdio_o(dac_sdio_o), .dac_sdio_oe(dac_sdio_oe),
  .dac_sdio_i(dac_sdio_i));
